// [inc/psp_pkg.sv]
package psp_pkg;

    // Frame geometry
    localparam int FRAME_BITS = 32;
    localparam int DATA_BITS = 24;
    localparam int ADDR_BITS = 5;
    localparam int CHIP_BITS = 3;
    localparam int CNT_BITS = 8;
    localparam int SRC_COUNT = 32;
    localparam int KEEP_COUNT = 6;
    localparam logic [CNT_BITS-1:0] FRAME_EDGES = 8'h20;
    localparam logic [CNT_BITS-1:0] DATA_EDGES = 8'h18;

    // Register offsets
    localparam logic [ADDR_BITS-1:0] REG_READ_PTR = 5'h00;
    localparam logic [ADDR_BITS-1:0] REG_POWER = 5'h01;
    localparam logic [ADDR_BITS-1:0] REG_REFERENCE_DIVIDE_VALUE = 5'h02;
    localparam logic [ADDR_BITS-1:0] REG_ANALOG_EN = 5'h08;
    localparam logic [ADDR_BITS-1:0] REG_GPO_CTRL = 5'h0f;

    localparam logic [CHIP_BITS-1:0] OWN_CHIP_ADDR = 3'h0;

    // Reset values
    localparam logic [9:0] POWER_RST = 10'h003;
    localparam logic [13:0] REFERENCE_DIVIDE_VALUE_RST = 14'h0001;
    localparam logic [23:0] ANALOG_EN_RST = 24'h01bfff;
    localparam logic [23:0] GPO_CTRL_RST = 24'h000001;

    // Field positions
    localparam int PTR_SOFT_RST_BIT = 5;
    localparam int PWR_PIN_SEL_BIT = 0;
    localparam int PWR_SPI_EN_BIT = 1;
    localparam int PWR_KEEP_LSB = 2;
    localparam int AEN_PIN_DRV_BIT = 5;
    localparam int GPO_SRC_LSB = 0;
    localparam int GPO_FORCE_BIT = 6;
    localparam int GPO_KEEP_BIT = 7;
    localparam int GPO_PU_OFF_BIT = 8;
    localparam int GPO_PD_OFF_BIT = 9;

    typedef struct packed {
        logic [DATA_BITS-1:0] data;
        logic [ADDR_BITS-1:0] addr;
        logic [CHIP_BITS-1:0] chip;
    } psp_frame_t;

    typedef struct packed {
        logic [CNT_BITS-1:0] edge_cnt;
        logic [CNT_BITS-1:0] edge_gray;
        psp_frame_t shift_in;
        logic [DATA_BITS-1:0] rd_shift;
        logic rd_bit;
    } psp_link_state_t;

    typedef struct packed {
        logic chip_on;
        logic [KEEP_COUNT-1:0] block_on;
    } psp_power_t;

    typedef struct packed {
        logic pin_oe;
        logic pullup_off;
        logic pulldown_off;
    } psp_driver_t;

    typedef struct packed {
        logic sen_s1;
        logic sen_s2;
        logic sen_q;
        logic [CNT_BITS-1:0] gray_s1;
        logic [CNT_BITS-1:0] gray_s2;
        psp_frame_t frame_s1;
        psp_frame_t frame_s2;
        logic chip_en_s1;
        logic chip_en_s2;
        logic [SRC_COUNT-1:0] src_s1;
        logic [SRC_COUNT-1:0] src_s2;
        logic [CNT_BITS-1:0] base;
        logic [ADDR_BITS-1:0] rd_ptr;
        logic [9:0] power_ctrl;
        logic [13:0] reference_divide_value;
        logic [23:0] analog_en;
        logic [23:0] gpo_ctrl;
        logic addressed;
        logic read_mode;
        logic use_sdo;
        logic [DATA_BITS-1:0] rd_word;
        logic gpo_bit;
        psp_driver_t drv;
        psp_power_t power;
    } psp_ref_state_t;

endpackage

// [core/psp_serial_port.sv]
`timescale 1ns/10ps

// How it works
// - Device samples serial data on rising edges; first 24 are data.
// - Edges 25 to 29 carry the 5-bit register address, MSB first.
// - Edges 30 to 32 carry the chip address; only 000 is answered.
// - Strobe rising after edge 32 commits the word to the register.
// - Every frame shifts out the register chosen by the read pointer.
// - In the following frame read data goes out on the first 24 rising edges, then zeros.
// - Read works without strobe; strobe rise returns pin to general output.
// - After reset the pin driver is off except during addressed reads.
// - Driver enables on chip address 000 or a strobe before a full address.
// - Force bit keeps the general output on the pin during reads.
// - Pin enable bit cleared turns the driver off above all else.
// - Two control bits switch off pull-up or pull-down driver halves.
// - Five-bit source field picks the general output; default lock detect.
// - Keep bit drives the pin outside reads with the general output.
// - Register zero reads a fixed identification code; writes leave it.
// - Register zero write loads read pointer, bit 5 soft-resets.
// - Enable select chooses between enable pin and the enable bit.
// - Six keep bits hold individual blocks powered regardless of enable.
// - Register two holds a 14-bit reference divider, 1 to 16383.
// - With keep bit clear, foreign chip addresses turn the driver off.
// - Reset restores all port registers to defaults; soft reset all but the read pointer.
module psp_serial_port #(
    parameter logic [23:0] IDENTITY_CODE = 24'h5a5a01 // Arbitrary value
) (
    input wire logic ref_clk_i,                    // Core clock, 20 MHz
    input wire logic rst_n_i,                      // Reset, active low
    input wire logic serial_clk_i,                 // Link clock from host
    input wire logic serial_data_i,                // Serial data in
    input wire logic serial_load_strobe_i,         // Load strobe
    input wire logic chip_enable_pin_i,            // Chip enable pin
    input wire logic [31:0] output_sources_i,      // General output sources
    input wire logic lock_or_readback_pin_i,       // Shared pin level
    output logic lock_or_readback_pin_o,           // Shared pin data
    output logic lock_or_readback_pin_oe_o,        // Shared pin enable
    output logic pin_pullup_off_o,                 // Pull-up half off
    output logic pin_pulldown_off_o,               // Pull-down half off
    output logic chip_enabled_o,                   // Chip powered up
    output logic [5:0] block_on_o,                 // Per-block power
    output logic [13:0] reference_divide_value_o   // Reference divider
);

    psp_pkg::psp_link_state_t l;
    psp_pkg::psp_link_state_t next_l;
    psp_pkg::psp_ref_state_t r;
    psp_pkg::psp_ref_state_t next_r;

    logic [psp_pkg::CNT_BITS-1:0] link_idx;
    logic [psp_pkg::CNT_BITS-1:0] link_cnt_inc;
    logic [psp_pkg::CNT_BITS-1:0] cnt_bin;
    logic [psp_pkg::CNT_BITS-1:0] frame_len;
    logic sen_rise;
    logic sen_fall;
    logic frame_hit;
    logic soft_reset;
    logic [4:0] src_sel;

    // Link side: runs only while the host clocks a frame. The frame start
    // is found from the edge count against the count captured at the last
    // strobe; that base and the read word only change while the strobe is
    // high and the host keeps the clock still, so they are quasi-static.
    assign link_idx = l.edge_cnt - r.base;
    assign link_cnt_inc = l.edge_cnt + 8'h01;

    always_comb begin
        next_l = l;
        next_l.edge_cnt = link_cnt_inc;
        next_l.edge_gray = link_cnt_inc ^ (link_cnt_inc >> 1);
        // Data, register address and chip address arrive MSB first
        next_l.shift_in = psp_pkg::psp_frame_t'(
            {l.shift_in[psp_pkg::FRAME_BITS-2:0], serial_data_i});
        if (link_idx == '0) begin
            // First edge of a frame presents the pointed register
            next_l.rd_bit = r.rd_word[psp_pkg::DATA_BITS-1];
            next_l.rd_shift = {r.rd_word[psp_pkg::DATA_BITS-2:0], 1'b0};
        end else begin
            // Past the data bits the remaining edges shift out zeros
            next_l.rd_bit = l.rd_shift[psp_pkg::DATA_BITS-1];
            next_l.rd_shift = {l.rd_shift[psp_pkg::DATA_BITS-2:0], 1'b0};
        end
    end

    // The host clock stands still at reset release, so an asynchronous
    // reset is the only way to give this side a defined start.
    always_ff @(posedge serial_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    // Gray-coded edge count decoded after its two-stage synchroniser
    genvar gi;
    generate
        for (gi = 0; gi < psp_pkg::CNT_BITS; gi++) begin : g_gray
            assign cnt_bin[gi] = ^r.gray_s2[psp_pkg::CNT_BITS-1:gi];
        end
    endgenerate

    assign sen_rise = r.sen_s2 & ~r.sen_q;
    assign sen_fall = ~r.sen_s2 & r.sen_q;
    assign frame_len = cnt_bin - r.base;
    // Exactly 32 edges and our chip address, else nothing is stored
    assign frame_hit = (frame_len == psp_pkg::FRAME_EDGES) &&
        (r.frame_s2.chip == psp_pkg::OWN_CHIP_ADDR);
    assign soft_reset = sen_rise && frame_hit &&
        (r.frame_s2.addr == psp_pkg::REG_READ_PTR) &&
        r.frame_s2.data[psp_pkg::PTR_SOFT_RST_BIT];
    assign src_sel = r.gpo_ctrl[psp_pkg::GPO_SRC_LSB +: 5];

    always_comb begin
        next_r = r;
        next_r.sen_s1 = serial_load_strobe_i;
        next_r.sen_s2 = r.sen_s1;
        next_r.sen_q = r.sen_s2;
        next_r.gray_s1 = l.edge_gray;
        next_r.gray_s2 = r.gray_s1;
        next_r.frame_s1 = l.shift_in;
        next_r.frame_s2 = r.frame_s1;
        next_r.chip_en_s1 = chip_enable_pin_i;
        next_r.chip_en_s2 = r.chip_en_s1;
        next_r.src_s1 = output_sources_i;
        next_r.src_s2 = r.src_s1;

        if (sen_rise) begin
            // Strobe edge closes the frame and returns the pin
            next_r.base = cnt_bin;
            next_r.read_mode = 1'b0;
            // Short frame: strobe came before the chip address was complete
            next_r.addressed = frame_hit ||
                (frame_len < psp_pkg::FRAME_EDGES);
        end
        if (sen_fall) begin
            // Next frame is a read only if this chip was addressed
            next_r.read_mode = r.addressed;
        end

        if (sen_rise && frame_hit) begin
            unique case (r.frame_s2.addr)
                psp_pkg::REG_READ_PTR: begin
                    // Identification code is constant; only pointer moves
                    next_r.rd_ptr = r.frame_s2.data[4:0];
                end
                psp_pkg::REG_POWER: begin
                    next_r.power_ctrl = r.frame_s2.data[9:0];
                end
                psp_pkg::REG_REFERENCE_DIVIDE_VALUE: begin
                    // Zero is outside the legal divide range
                    if (r.frame_s2.data[13:0] != '0) begin
                        next_r.reference_divide_value = r.frame_s2.data[13:0];
                    end
                end
                psp_pkg::REG_ANALOG_EN: begin
                    next_r.analog_en = r.frame_s2.data;
                end
                psp_pkg::REG_GPO_CTRL: begin
                    next_r.gpo_ctrl = r.frame_s2.data;
                end
                default: begin
                end
            endcase
        end

        if (soft_reset) begin
            next_r.power_ctrl = psp_pkg::POWER_RST;
            next_r.reference_divide_value = psp_pkg::REFERENCE_DIVIDE_VALUE_RST;
            next_r.analog_en = psp_pkg::ANALOG_EN_RST;
            next_r.gpo_ctrl = psp_pkg::GPO_CTRL_RST;
        end

        // Read word follows the pointer; held stable between frames
        unique case (r.rd_ptr)
            psp_pkg::REG_READ_PTR: next_r.rd_word = IDENTITY_CODE;
            psp_pkg::REG_POWER: next_r.rd_word = {14'h0000, r.power_ctrl};
            psp_pkg::REG_REFERENCE_DIVIDE_VALUE: next_r.rd_word = {10'h000, r.reference_divide_value};
            psp_pkg::REG_ANALOG_EN: next_r.rd_word = r.analog_en;
            psp_pkg::REG_GPO_CTRL: next_r.rd_word = r.gpo_ctrl;
            default: next_r.rd_word = '0;
        endcase

        next_r.gpo_bit = r.src_s2[src_sel];
        // Force bit blocks the automatic switch to read data
        next_r.use_sdo = r.read_mode &&
            !r.gpo_ctrl[psp_pkg::GPO_FORCE_BIT];
        // Enable bit wins; otherwise reads or the keep bit drive
        next_r.drv.pin_oe = r.analog_en[psp_pkg::AEN_PIN_DRV_BIT] &&
            (r.read_mode || r.gpo_ctrl[psp_pkg::GPO_KEEP_BIT]);
        next_r.drv.pullup_off = r.gpo_ctrl[psp_pkg::GPO_PU_OFF_BIT];
        next_r.drv.pulldown_off = r.gpo_ctrl[psp_pkg::GPO_PD_OFF_BIT];

        // Enable select set: pin decides; clear: the enable bit decides
        next_r.power.chip_on = r.power_ctrl[psp_pkg::PWR_PIN_SEL_BIT] ?
            r.chip_en_s2 : r.power_ctrl[psp_pkg::PWR_SPI_EN_BIT];
        next_r.power.block_on = {psp_pkg::KEEP_COUNT{r.power.chip_on}} |
            r.power_ctrl[psp_pkg::PWR_KEEP_LSB +: psp_pkg::KEEP_COUNT];
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            r <= '0;
            r.power_ctrl <= psp_pkg::POWER_RST;
            r.reference_divide_value <= psp_pkg::REFERENCE_DIVIDE_VALUE_RST;
            r.analog_en <= psp_pkg::ANALOG_EN_RST;
            r.gpo_ctrl <= psp_pkg::GPO_CTRL_RST;
            r.rd_word <= IDENTITY_CODE;
            r.power.chip_on <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // Read bits must follow the host clock, so the pin data is picked
    // between the link-side bit flop and the core-side output flop.
    assign lock_or_readback_pin_o = r.use_sdo ? l.rd_bit : r.gpo_bit;
    assign lock_or_readback_pin_oe_o = r.drv.pin_oe;
    assign pin_pullup_off_o = r.drv.pullup_off;
    assign pin_pulldown_off_o = r.drv.pulldown_off;
    assign chip_enabled_o = r.power.chip_on;
    assign block_on_o = r.power.block_on;
    assign reference_divide_value_o = r.reference_divide_value;

endmodule

// [tb/psp_host_model.sv]
`timescale 1ns/10ps
module psp_host_model (
    output logic serial_clk_o,          // Link clock, only within frames
    output logic serial_data_o,         // Serial data to the device
    output logic serial_load_strobe_o,  // Load strobe
    input wire logic pin_level_i        // Resolved shared pin level
);
    logic [31:0] rd_word;
    initial begin
        serial_clk_o = 1'b0;
        serial_data_o = 1'b0;
        serial_load_strobe_o = 1'b0;
        rd_word = 32'h0;
    end
    // Sends the first n bits of w; a short n aborts the frame early
    task automatic frame(input logic [31:0] w, input int n);
        rd_word = 32'h0;
        for (int i = 0; i < n; i++) begin
            serial_data_o = w[31-i];
            #32;
            serial_clk_o = 1'b1;
            #32;
            serial_clk_o = 1'b0;
            rd_word = {rd_word[30:0], pin_level_i};
        end
        // Released data line flips so stale bits never look valid
        serial_data_o = ~serial_data_o;
        #50;
        serial_load_strobe_o = 1'b1;
        #400;
        serial_load_strobe_o = 1'b0;
        #400;
    endtask
endmodule

// [tb/psp_serial_port_monitor.sv]
`timescale 1ns/10ps
module psp_serial_port_monitor (
    input wire logic ref_clk_i,                  // Core clock
    input wire logic rst_n_i,                    // Reset, active low
    input wire logic serial_load_strobe_i,       // Load strobe
    input wire logic lock_or_readback_pin_oe_o,  // Pin enable
    input wire logic pin_pullup_off_o,           // Pull-up off
    input wire logic pin_pulldown_off_o,         // Pull-down off
    input wire logic chip_enabled_o,             // Chip powered
    input wire logic [5:0] block_on_o,           // Block power
    input wire logic [13:0] reference_divide_value_o // Divider
);
    default clocking mon_cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    a_reference_divide_value_commit:
    assert property (!$stable(reference_divide_value_o) |->
        $past(serial_load_strobe_i, 3)) else $error("divider moved");
    a_reference_divide_value_nonzero:
    assert property (reference_divide_value_o != 14'h0000)
        else $error("divider is zero");
    a_pull_commit:
    assert property ($changed(pin_pullup_off_o) || $changed(pin_pulldown_off_o)
        |-> $past(serial_load_strobe_i, 3)) else $error("pull bits moved");
    a_oe_strobe_window:
    assert property ($changed(lock_or_readback_pin_oe_o) |->
        $past(serial_load_strobe_i, 2) != $past(serial_load_strobe_i, 6))
        else $error("driver enable moved off strobe");
    a_blocks_follow_chip:
    assert property (chip_enabled_o |=> (block_on_o == 6'h3f))
        else $error("blocks off while chip on");
    a_oe_steady_high:
    assert property (serial_load_strobe_i [*8] |->
        $stable(lock_or_readback_pin_oe_o)) else $error("oe moved, strobe high");
    a_oe_steady_low:
    assert property (!serial_load_strobe_i [*8] |->
        $stable(lock_or_readback_pin_oe_o)) else $error("oe moved, strobe low");
    a_reference_divide_value_quiet:
    assert property (!serial_load_strobe_i [*8] |->
        $stable(reference_divide_value_o)) else $error("divider moved idle");
    c_oe_rise: cover property ($rose(lock_or_readback_pin_oe_o));
    c_chip_off: cover property ($fell(chip_enabled_o));
    c_div_write: cover property ($changed(reference_divide_value_o));
endmodule
bind psp_serial_port psp_serial_port_monitor u_psp_serial_port_monitor (
    .ref_clk_i, .rst_n_i, .serial_load_strobe_i, .lock_or_readback_pin_oe_o,
    .pin_pullup_off_o, .pin_pulldown_off_o, .chip_enabled_o, .block_on_o,
    .reference_divide_value_o);

// [tb/psp_serial_port_tb.sv]
`timescale 1ns/10ps
module psp_serial_port_tb;
    localparam logic [23:0] ID_VAL = 24'h3c3c11; // Arbitrary value
    logic ref_clk_i;
    logic rst_n_i;
    logic chip_pin;
    logic pin_last;
    logic [31:0] src;
    logic [31:0] q;
    wire logic sclk, sdi, serial_load_strobe, pin_o, oe, pu, pd, chip_on, pin_lvl;
    wire logic [5:0] blk;
    wire logic [13:0] rdiv;
    int failures;
    int tests_run;
    // Undriven pin toggles so a stale value never reads as good data
    assign pin_lvl = oe ? pin_o : ~pin_last;
    always @(posedge ref_clk_i) pin_last <= pin_lvl;
    psp_serial_port #(.IDENTITY_CODE(ID_VAL)) u_psp_serial_port (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .serial_clk_i(sclk),
        .serial_data_i(sdi), .serial_load_strobe_i(serial_load_strobe),
        .chip_enable_pin_i(chip_pin), .output_sources_i(src),
        .lock_or_readback_pin_i(pin_lvl), .lock_or_readback_pin_o(pin_o),
        .lock_or_readback_pin_oe_o(oe), .pin_pullup_off_o(pu),
        .pin_pulldown_off_o(pd), .chip_enabled_o(chip_on),
        .block_on_o(blk), .reference_divide_value_o(rdiv));
    psp_host_model u_psp_host_model (.serial_clk_o(sclk),
        .serial_data_o(sdi), .serial_load_strobe_o(serial_load_strobe), .pin_level_i(pin_lvl));
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [23:0] d);
        u_psp_host_model.frame({d, a, 3'h0}, 32);
    endtask
    task automatic rd(input logic [4:0] a, input logic ow);
        wr(5'h00, {19'h0, a});
        chk("oe in read", 32'(oe), 32'(ow));
        wr(5'h00, {19'h0, a});
        q = u_psp_host_model.rd_word;
    endtask
    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        #2000000;
        failures++;
        close_out();
    end
    initial begin
        rst_n_i = 1'b0;
        chip_pin = 1'b1;
        src = 32'h00000002;
        pin_last = 1'b0;
        failures = 0;
        tests_run = 0;
        repeat (8) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        repeat (6) @(negedge ref_clk_i);
        chk("divider reset", 32'(rdiv), 32'h1);
        chk("pin reset", {28'h0, oe, pu, pd, chip_on}, 32'h1);
        rd(5'h00, 1'b1);
        chk("identity", q, {ID_VAL, 8'h00});
        wr(5'h02, 24'h003fff);
        chk("divider max", 32'(rdiv), 32'h3fff);
        wr(5'h02, 24'h000000);
        u_psp_host_model.frame({24'h5, 5'h02, 3'h5}, 32);
        chk("foreign oe", 32'(oe), 32'h0);
        u_psp_host_model.frame({24'h7, 5'h02, 3'h0}, 31);
        chk("short oe", 32'(oe), 32'h1);
        rd(5'h02, 1'b1);
        chk("divider kept", q, {10'h0, 14'h3fff, 8'h0});
        chip_pin = 1'b0;
        repeat (10) @(negedge ref_clk_i);
        chk("pin off", {25'h0, chip_on, blk}, 32'h0);
        chip_pin = 1'b1;
        wr(5'h01, 24'h0000fc);
        chk("keep blocks", {25'h0, chip_on, blk}, 32'h3f);
        rd(5'h01, 1'b1);
        chk("power reg", q, 32'h0000fc00);
        wr(5'h0f, 24'h000381);
        u_psp_host_model.frame({24'h0, 5'h02, 3'h6}, 32);
        chk("keep drive", {28'h0, oe, pu, pd, pin_lvl}, 32'hf);
        wr(5'h0f, 24'h0000c1);
        rd(5'h02, 1'b1);
        chk("forced out", q, 32'hffffffff);
        wr(5'h08, 24'h01bfdf);
        chk("pin off bit", 32'(oe), 32'h0);
        wr(5'h00, 24'h000020);
        chk("soft reset", {17'h0, rdiv, pu, pd}, 32'h4);
        rd(5'h0f, 1'b1);
        chk("source reset", q, 32'h00000100);
        rd(5'h00, 1'b1);
        chk("identity kept", q, {ID_VAL, 8'h00});
        rd(5'h1e, 1'b1);
        chk("unmapped", q, 32'h0);
        close_out();
    end
endmodule
